// >>> rtl/dpa_pkg.sv
// Purpose: constants for the dual-port RAM port controller
// Assumes: 200 MHz clock, one controller per RAM port
// Notes:   times in ns, cycle counts derived from them
package dpa_pkg;
  // ==========================================================
  // clock and pin timing
  localparam int CLK_NS           = 5;
  localparam int ACCESS_NS        = 15;
  localparam int WRITE_PULSE_NS   = 12;
  localparam int WRITE_HOLD_NS    = 13;  // write_hold_after_release
  localparam int FLAG_UPDATE_NS   = 10;  // flag_update_pulse
  localparam int FLAG_GAP_NS      = 5;   // flag_write_to_read_gap
  localparam int SYNC_STAGES      = 2;
  // least times round up; read data also passes the synchroniser
  localparam logic [7:0] ACCESS_CYC =
    8'((ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [7:0] PULSE_CYC  = 8'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC   =
    8'((WRITE_HOLD_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [7:0] UPDATE_CYC = 8'((FLAG_UPDATE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GAP_CYC    = 8'((FLAG_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RECOVER_CYC = (UPDATE_CYC > GAP_CYC) ? UPDATE_CYC : GAP_CYC;
  localparam logic [7:0] ACTIVE_CYC  = (ACCESS_CYC > PULSE_CYC) ? ACCESS_CYC : PULSE_CYC;
  // ==========================================================
  // register word addresses
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_ADDR    = 3'h1;
  localparam logic [2:0] REG_WDATA   = 3'h2;
  localparam logic [2:0] REG_RDATA   = 3'h3;
  localparam logic [2:0] REG_STATUS  = 3'h4;
  localparam logic [2:0] REG_IRQ_STS = 3'h5;
  localparam logic [2:0] REG_IRQ_CLR = 3'h6;
  localparam logic [2:0] REG_IRQ_EN  = 3'h7;
  // control fields
  localparam int CTRL_GO     = 0;
  localparam int CTRL_WRITE  = 1;
  localparam int CTRL_FLAG   = 2;
  localparam int CTRL_MASTER = 3;
  // status fields
  localparam int ST_BUSY_CMD  = 0;
  localparam int ST_BUSY_PIN  = 1;
  localparam int ST_MBOX_PIN  = 2;
  localparam int ST_MASTER    = 3;
  // event bits
  localparam int EV_DONE   = 0;
  localparam int EV_STALL  = 1;
  localparam int EV_MBOX   = 2;
  localparam int EV_W      = 3;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // ==========================================================
  typedef enum logic [5:0] {
    S_IDLE    = 6'b000001,
    S_SETUP   = 6'b000010,
    S_ACTIVE  = 6'b000100,
    S_STALL   = 6'b001000,
    S_RELEASE = 6'b010000,
    S_RECOVER = 6'b100000
  } dpa_state_t;
endpackage

// >>> rtl/dpa_port_ctrl.sv
// Purpose: drives one port of an asynchronous dual-port RAM with flags
// Assumes: pins are asynchronous to i_clk; Avalon-MM slave, 32-bit words
// Notes:   one access per command; flag acquire is a write of 0 then a read
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.

// Summary of operation
// - write starts with both low, ends when either rises
// - read/write held high whenever the address changes
// - read/write held high through every read cycle
// - RAM uses enable low, flag high; flags use enable high, select low
// - every flag read is framed by its own select cycle
// - flag readback waits the write-to-read gap after a write
// - select and output enable stay high the update pulse after access
// - stalled writer keeps read/write low the hold time after busy rises
module dpa_port_ctrl
  import dpa_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // avalon-mm slave
  input  wire logic [2:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  output logic                   o_irq,
  // ram port pins
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_rw_n,
  output logic                   o_shared_flag_select_n,
  output logic                   o_master_sel,
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_oe,
  input  wire logic              i_busy_n,
  input  wire logic              i_int_n
);
  // ==========================================================
  // pin synchronisers
  // pins idle high, so the busy and int stages reset high and reset leaves no false edge; data stages reset low
  logic [DATA_W-1:0] data_m;
  logic [DATA_W-1:0] data_s;
  logic              busy_m;
  logic              busy_n_s;
  logic              int_m;
  logic              int_n_s;
  logic              int_n_d;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_m   <= '0;
      data_s   <= '0;
      busy_m   <= 1'b1;
      busy_n_s <= 1'b1;
      int_m    <= 1'b1;
      int_n_s  <= 1'b1;
      int_n_d  <= 1'b1;
    end else begin
      data_m   <= i_data;
      data_s   <= data_m;
      busy_m   <= i_busy_n;
      busy_n_s <= busy_m;
      int_m    <= i_int_n;
      int_n_s  <= int_m;
      int_n_d  <= int_n_s;
    end
  end

  // ==========================================================
  // register file
  logic              cmd_write;
  logic              cmd_flag;
  logic              master_mode;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic [DATA_W-1:0] rdata;
  logic [EV_W-1:0]   irq_sts;
  logic [EV_W-1:0]   irq_en;
  dpa_state_t        state;
  dpa_state_t        next_state;
  logic [7:0]        cnt;
  logic [7:0]        next_cnt;

  wire bus_req  = i_avs_read | i_avs_write;
  wire bus_take = bus_req & ~o_avs_waitrequest;
  wire wr_take  = bus_take & i_avs_write;
  wire wr_ctrl  = wr_take & (i_avs_address == REG_CTRL);
  wire wr_clr   = wr_take & (i_avs_address == REG_IRQ_CLR);
  wire idle     = (state == S_IDLE);
  // a go while a command runs is dropped together with its other fields
  wire go       = wr_ctrl & i_avs_writedata[CTRL_GO] & idle;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = UNMAPPED_RD;
    case (i_avs_address)
      REG_CTRL: begin
        rd_mux[CTRL_WRITE]  = cmd_write;
        rd_mux[CTRL_FLAG]   = cmd_flag;
        rd_mux[CTRL_MASTER] = master_mode;
      end
      REG_ADDR:    rd_mux[ADDR_W-1:0] = cmd_addr;
      REG_WDATA:   rd_mux[DATA_W-1:0] = cmd_wdata;
      REG_RDATA:   rd_mux[DATA_W-1:0] = rdata;
      REG_STATUS: begin
        rd_mux[ST_BUSY_CMD] = ~idle;
        rd_mux[ST_BUSY_PIN] = ~busy_n_s;
        rd_mux[ST_MBOX_PIN] = ~int_n_s;
        rd_mux[ST_MASTER]   = master_mode;
      end
      REG_IRQ_STS: rd_mux[EV_W-1:0] = irq_sts;
      REG_IRQ_EN:  rd_mux[EV_W-1:0] = irq_en;
      default:     rd_mux = UNMAPPED_RD;
    endcase
  end

  // one wait cycle, then the answer edge
  // a request still held after its answer edge is taken once more
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (bus_req & o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_write   <= 1'b0;
      cmd_flag    <= 1'b0;
      master_mode <= 1'b1;
      cmd_addr    <= '0;
      cmd_wdata   <= '0;
      irq_en      <= '0;
    end else begin
      if (wr_ctrl & idle) begin
        cmd_write   <= i_avs_writedata[CTRL_WRITE];
        cmd_flag    <= i_avs_writedata[CTRL_FLAG];
        master_mode <= i_avs_writedata[CTRL_MASTER];
      end
      if (wr_take & idle & (i_avs_address == REG_ADDR)) begin
        cmd_addr <= i_avs_writedata[ADDR_W-1:0];
      end
      if (wr_take & idle & (i_avs_address == REG_WDATA)) begin
        cmd_wdata <= i_avs_writedata[DATA_W-1:0];
      end
      if (wr_take & (i_avs_address == REG_IRQ_EN)) begin
        irq_en <= i_avs_writedata[EV_W-1:0];
      end
    end
  end

  // ==========================================================
  // access sequencer
  // the count runs down to zero and rests there
  wire cnt_done = (cnt == 8'h00);

  always_comb begin
    next_state = state;
    next_cnt   = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
    case (state)
      S_IDLE: begin
        if (go) begin
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        next_state = S_ACTIVE;
        next_cnt   = ACTIVE_CYC - 8'h01;
      end
      S_ACTIVE: begin
        if (cnt_done & ~busy_n_s) begin
          next_state = S_STALL;
        end else if (cnt_done) begin
          next_state = S_RELEASE;
        end
      end
      S_STALL: begin
        if (~busy_n_s) begin
          next_cnt = HOLD_CYC - 8'h01;
        end else if (cnt_done) begin
          next_state = S_RELEASE;
        end
      end
      // enable (select for flags) rises here and read/write a cycle later, so it ends the write
      S_RELEASE: begin
        next_state = S_RECOVER;
        next_cnt   = RECOVER_CYC - 8'h01;
      end
      S_RECOVER: begin
        if (cnt_done) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // the command bits load at the go edge itself, so the data drive looks at
  // the incoming write bit there: a read after a write must not drive in setup
  wire wr_bit    = go ? i_avs_writedata[CTRL_WRITE] : cmd_write;
  wire next_on   = (next_state == S_ACTIVE) | (next_state == S_STALL);
  wire next_wr   = cmd_write & (next_on | (next_state == S_RELEASE));
  // data pins driven from setup through release, on writes only
  wire next_drv  = wr_bit & (next_state != S_IDLE) & (next_state != S_RECOVER);
  wire next_ce_n  = ~(next_on & ~cmd_flag);
  wire next_sel_n = ~(next_on & cmd_flag);
  wire next_oe_n  = ~(next_on & ~cmd_write);
  // read data sampled once, on leaving the access
  wire capture    = ~cmd_write & (next_state == S_RELEASE) & (state != S_RELEASE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
      cnt   <= 8'h00;
      rdata <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (capture) begin
        rdata <= data_s;
      end
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_addr                 <= '0;
      o_ce_n                 <= 1'b1;
      o_oe_n                 <= 1'b1;
      o_rw_n                 <= 1'b1;
      o_shared_flag_select_n <= 1'b1;
      o_master_sel           <= 1'b1;
      o_data                 <= '0;
      o_data_oe              <= 1'b0;
    end else begin
      if (go) begin
        o_addr <= cmd_addr;
      end
      o_ce_n                 <= next_ce_n;
      o_shared_flag_select_n <= next_sel_n;
      o_rw_n       <= ~next_wr;
      o_oe_n       <= next_oe_n;
      // busy acts as input when low
      o_master_sel <= master_mode;
      o_data       <= cmd_wdata;
      o_data_oe    <= next_drv;
    end
  end

  // ==========================================================
  // interrupts: set beats clear
  wire [EV_W-1:0] ev;
  assign ev[EV_DONE]  = (state == S_RECOVER) & cnt_done;
  assign ev[EV_STALL] = (state == S_ACTIVE) & cnt_done & ~busy_n_s;
  // mailbox event on the falling edge of the synchronised pin
  assign ev[EV_MBOX]  = int_n_d & ~int_n_s;

  wire [EV_W-1:0] clr = wr_clr ? i_avs_writedata[EV_W-1:0] : '0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_sts <= '0;
      o_irq   <= 1'b0;
    end else begin
      irq_sts <= (irq_sts & ~clr) | ev;
      o_irq   <= |(((irq_sts & ~clr) | ev) & irq_en);
    end
  end

endmodule // dpa_port_ctrl

// >>> tb/dpa_port_ctrl_test.sv
// Purpose: register-level test of the RAM port controller
// Assumes: RAM model on the pins, opposite port scripted here
// Notes:   expectations follow the register map and model rules
module dpa_port_ctrl_test
  import dpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_rst = 1, rd = 0, wr = 0, int_n = 1;
  logic        oth_ce_n = 1, slv_busy_n = 1;
  logic        wreq, irq, ce_n, oe_n, rw_n, sel_n, ms, d_oe, busy_n;
  logic [2:0]  adr = 3'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [12:0] addr, oth_addr = 13'h0;
  logic [7:0]  dq, d, oth_own = 8'h0;
  int          n_mismatch = 0, checks = 0, cyc = 0;
  logic [12:0] ta[3] = '{13'h0000, 13'h1FFF, 13'h01A5};
  logic [7:0]  tv[3] = '{8'h5A, 8'hA5, 8'h3C};
  logic [12:0] fa[4] = '{13'h0003, 13'h0005, 13'h0003, 13'h1FFB};
  logic [7:0]  fv[4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [31:0] fe[4] = '{32'hFE, 32'hFF, 32'hFF, 32'hFE};
  always #2.5 i_clk = ~i_clk;
  dpa_port_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_rw_n(rw_n), .o_shared_flag_select_n(sel_n), .o_master_sel(ms), .i_data(dq),
    .o_data(d), .o_data_oe(d_oe), .i_busy_n(busy_n), .i_int_n(int_n));
  dpa_ram_model ram (.i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_rw_n(rw_n),
    .i_sel_n(sel_n), .i_ms(ms), .i_d(d), .i_d_oe(d_oe), .o_d(dq), .o_busy_n(busy_n),
    .i_oth_addr(oth_addr), .i_oth_ce_n(oth_ce_n), .i_oth_own(oth_own),
    .i_slv_busy_n(slv_busy_n));
  // ==========================================
  // reporting and bus tasks
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] v);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= v;
    do @(posedge i_clk); while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [31:0] e);
    av(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic go(input logic [31:0] c, input logic [12:0] a, input logic [7:0] v);
    av(1'h1, REG_ADDR, {19'h0, a});
    av(1'h1, REG_WDATA, {24'h0, v});
    av(1'h1, REG_CTRL, c);
  endtask
  task automatic fin;
    do av(1'h0, REG_STATUS, 32'h0); while (q[ST_BUSY_CMD] !== 1'h0);
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // ==========================================
  // test sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'h0;
    rc(REG_CTRL, 32'h8);
    rc(REG_STATUS, 32'h8);
    av(1'h1, REG_STATUS, 32'h7);
    rc(REG_STATUS, 32'h8);
    rc(REG_IRQ_STS, 32'h0);
    rc(REG_IRQ_EN, 32'h0);
    rc(REG_IRQ_CLR, 32'h0);
    for (int i = 0; i < 3; i++) begin
      go(32'hB, ta[i], tv[i]);
      fin;
    end
    for (int i = 0; i < 3; i++) begin
      go(32'h9, ta[i], 8'h00);
      fin;
      rc(REG_RDATA, {24'h0, tv[i]});
    end
    oth_own <= 8'h20;
    for (int i = 0; i < 4; i++) begin
      go(32'hF, fa[i], fv[i]);
      fin;
      go(32'hD, fa[i], 8'h00);
      fin;
      rc(REG_RDATA, fe[i]);
    end
    for (int i = 0; i < 2; i++) begin
      av(1'h1, REG_IRQ_CLR, 32'h7);
      oth_addr <= i ? 13'h01A5 : 13'h11A5;
      oth_ce_n <= 1'h0;
      go(32'hB, 13'h01A5, 8'(8'h70 + i));
      repeat (20) @(posedge i_clk);
      rc(REG_STATUS, i ? 32'hB : 32'h8);
      oth_ce_n <= 1'h1;
      fin;
      rc(REG_IRQ_STS, i ? 32'h3 : 32'h1);
      chk({24'h0, ram.mem[13'h01A5]}, 32'h70 + i);
    end
    av(1'h1, REG_IRQ_CLR, 32'h7);
    go(32'hB, 13'h01A5, 8'h7E);
    repeat (2) @(posedge i_clk);
    oth_ce_n <= 1'h0;
    fin;
    oth_ce_n <= 1'h1;
    rc(REG_IRQ_STS, 32'h1);
    chk({24'h0, ram.mem[13'h01A5]}, 32'h7E);
    slv_busy_n <= 1'h0;
    go(32'h3, 13'h0ABC, 8'h66);
    repeat (20) @(posedge i_clk);
    rc(REG_STATUS, 32'h3);
    slv_busy_n <= 1'h1;
    fin;
    chk({24'h0, ram.mem[13'h0ABC]}, 32'h66);
    av(1'h1, REG_IRQ_CLR, 32'h7);
    av(1'h1, REG_IRQ_EN, 32'h4);
    go(32'hB, 13'h0001, 8'h11);
    fin;
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    int_n <= 1'h0;
    repeat (4) @(posedge i_clk);
    chk({31'h0, irq}, 32'h1);
    rc(REG_IRQ_STS, 32'h5);
    rc(REG_STATUS, 32'hC);
    int_n <= 1'h1;
    av(1'h1, REG_IRQ_CLR, 32'h4);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    rc(REG_IRQ_STS, 32'h1);
    complete_run;
  end
endmodule // dpa_port_ctrl_test

// >>> tb/dpa_ram_model.sv
// Purpose: behavioural dual-port RAM port with eight flags
// Assumes: opposite port reduced to enable, address and flags held
// Notes:   released data lines show the inverse of their last value
module dpa_ram_model #(
  parameter int  ADDR_W  = 13,
  parameter int  DATA_W  = 8,
  parameter real HOLD_NS = 13.0
) (
  // controller pins
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_rw_n,
  input  wire logic              i_sel_n,
  input  wire logic              i_ms,
  input  wire logic [DATA_W-1:0] i_d,
  input  wire logic              i_d_oe,
  output logic      [DATA_W-1:0] o_d,
  output logic                   o_busy_n,
  // opposite port
  input  wire logic [ADDR_W-1:0] i_oth_addr,
  input  wire logic              i_oth_ce_n,
  input  wire logic [7:0]        i_oth_own,
  input  wire logic              i_slv_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0]        own    = 8'h0;
  logic [DATA_W-1:0] last   = '0;
  logic              late   = 1'h0;
  logic              to_flg = 1'h0;
  realtime           t_free = 0;
  wire logic         sel    = !(i_ce_n && i_sel_n);
  wire logic         wr     = !i_rw_n && sel;
  wire logic         drv    = !i_oe_n && i_rw_n && sel;
  wire logic         hit    = !i_ce_n && !i_oth_ce_n && i_addr == i_oth_addr;
  wire logic [DATA_W-1:0] q = i_ce_n ? {{(DATA_W-1){1'h1}}, !own[i_addr[2:0]]} : mem[i_addr];
  assign o_d = i_d_oe ? i_d : drv ? q : ~last;
  always @* if (i_d_oe || drv) last = i_d_oe ? i_d : q;
  // in master mode only the later port sees busy
  always @(negedge i_ce_n) late = !i_oth_ce_n;
  assign o_busy_n = i_ms ? !(hit && late) : i_slv_busy_n;
  always @(posedge o_busy_n) t_free = $realtime;
  always @(posedge wr) to_flg = i_ce_n;
  always @(negedge wr) begin
    if (o_busy_n && $realtime - t_free >= HOLD_NS) begin
      if (!to_flg) mem[i_addr] = o_d;
      else if (o_d[0]) own[i_addr[2:0]] = 1'h0;
      else if (!i_oth_own[i_addr[2:0]]) own[i_addr[2:0]] = 1'h1;
    end
  end
endmodule // dpa_ram_model

// >>> tb/dpa_sva.sv
// Purpose: pin and bus checks for the RAM port controller
// Assumes: one clock, reset active high
// Notes:   bound to dpa_port_ctrl
module dpa_sva
  import dpa_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 8
) (
  // clock, reset and bus
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic              o_avs_waitrequest,
  // ram port pins
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic              o_ce_n,
  input wire logic              o_oe_n,
  input wire logic              o_rw_n,
  input wire logic              o_shared_flag_select_n,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic              o_data_oe,
  input wire logic              i_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic idle_n = o_ce_n & o_shared_flag_select_n;
  // ==========================================
  // pin checks
  AST_ONE_TARGET: assert property (o_ce_n || o_shared_flag_select_n)
    else $error("both targets selected");
  AST_ADDR_RW: assert property (!$stable(o_addr) |-> o_rw_n && $past(o_rw_n))
    else $error("address moved in write");
  AST_READ_RW: assert property (!o_oe_n |-> o_rw_n)
    else $error("read with rw low");
  AST_WRITE_OE: assert property (!o_rw_n |-> o_oe_n && o_data_oe)
    else $error("write without data drive");
  AST_DATA_HOLD: assert property (!o_rw_n && !idle_n |=> o_data_oe && $stable(o_data))
    else $error("data moved at write end");
  AST_WRITE_END: assert property ($rose(idle_n) && !o_rw_n |=> o_rw_n && !o_data_oe)
    else $error("write not closed");
  AST_RECOVER: assert property ($rose(idle_n) |-> idle_n [*3])
    else $error("select gap too short");
  AST_BUSY_HOLD: assert property (!i_busy_n && !o_ce_n && !o_rw_n |=> !o_rw_n)
    else $error("write dropped under busy");
  AST_HOLD_AFTER_BUSY: assert property ($rose(i_busy_n) && !o_rw_n |=> !o_rw_n [*3])
    else $error("write released too soon after busy");
  // ==========================================
  // bus checks
  AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held two cycles");
endmodule // dpa_sva

bind dpa_port_ctrl dpa_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (.*);
